/* File: hw/pcei_regs.svh */
// Purpose: Register map, field positions, reset values for the pin change interrupt block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Definitions only
`ifndef PCEI_REGS_SVH
`define PCEI_REGS_SVH

`define PCEI_ADDR_W 8
`define PCEI_PIN_W 6

`define PCEI_OFF_RISE_EN 8'h00
`define PCEI_OFF_FALL_EN 8'h04
`define PCEI_OFF_FLAGS 8'h08
`define PCEI_OFF_CTRL 8'h0C
`define PCEI_OFF_STATUS 8'h10
`define PCEI_OFF_EVT 8'h14
`define PCEI_OFF_EVT_MASK 8'h18

`define PCEI_CTRL_MASTER_EN 0
`define PCEI_CTRL_MOD_DIS 1
`define PCEI_STAT_SUMMARY 0
`define PCEI_STAT_WAKE 1

`define PCEI_RST_PINS 6'h00
`define PCEI_ALL_PINS 6'h3F
`define PCEI_DBG_PINS 6'h3C

`define PCEI_RESP_OKAY 2'h0
`define PCEI_RESP_SLVERR 2'h2

`endif

/* File: hw/pcei_pkg.sv */
// Purpose: Types shared by the pin change interrupt block
// Assumes: Six monitored pins
// Notes: Offsets and values live in pcei_regs.svh
`include "pcei_regs.svh"

package pcei_pkg;

  typedef logic [`PCEI_PIN_W-1:0] pcei_pins_t;

  typedef struct packed {
    pcei_pins_t rise;
    pcei_pins_t fall;
  } pcei_edge_t;

  typedef struct packed {
    logic mod_dis;
    logic master_en;
  } pcei_ctrl_t;

  typedef enum {
    PCEI_SEL_RISE,
    PCEI_SEL_FALL,
    PCEI_SEL_FLAGS,
    PCEI_SEL_CTRL,
    PCEI_SEL_STATUS,
    PCEI_SEL_EVT,
    PCEI_SEL_EVT_MASK,
    PCEI_SEL_NONE
  } pcei_sel_t;

endpackage

/* File: hw/pcei_edge_det.sv */
// Purpose: Synchronise port pins and report rising and falling edges
// Assumes: Pins are asynchronous to i_clk
// Notes: Edges come out one cycle wide, two edges after the pin moves
`include "pcei_regs.svh"

module pcei_edge_det
  import pcei_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Pins and edges
  input wire pcei_pins_t i_pins,
  output pcei_edge_t o_edges
);

  pcei_pins_t meta_reg;
  pcei_pins_t sync_reg;
  pcei_pins_t prev_reg;

  genvar g;
  generate
    for (g = 0; g < `PCEI_PIN_W; g++) begin : g_pin
      // First stage feeds only the second stage
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_pins[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
      // Separate detectors, so both polarities can be armed at once
      assign o_edges.rise[g] = sync_reg[g] & ~prev_reg[g];
      assign o_edges.fall[g] = ~sync_reg[g] & prev_reg[g];
    end
  endgenerate

endmodule

/* File: hw/pcei_top.sv */
// Purpose: Per-pin edge detect with sticky change flags, summary request and wake
// Assumes: AXI4-Lite slave, one outstanding write and one read
// Notes: Offsets and bit positions sit in pcei_regs.svh
// Notes: Rule summary follows
`include "pcei_regs.svh"

module pcei_top
  import pcei_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`PCEI_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`PCEI_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Port pins and debugger state
  input wire pcei_pins_t i_port_a_pin,
  input wire logic i_debug_en,
  // Requests
  output logic o_change_irq,
  output logic o_wake,
  output logic o_irq
);

  // Shared address decode for both channels
  function automatic pcei_sel_t dec_addr(input logic [`PCEI_ADDR_W-1:0] addr);
    pcei_sel_t sel;
    sel = PCEI_SEL_NONE;
    case (addr)
      `PCEI_OFF_RISE_EN: sel = PCEI_SEL_RISE;
      `PCEI_OFF_FALL_EN: sel = PCEI_SEL_FALL;
      `PCEI_OFF_FLAGS: sel = PCEI_SEL_FLAGS;
      `PCEI_OFF_CTRL: sel = PCEI_SEL_CTRL;
      `PCEI_OFF_STATUS: sel = PCEI_SEL_STATUS;
      `PCEI_OFF_EVT: sel = PCEI_SEL_EVT;
      `PCEI_OFF_EVT_MASK: sel = PCEI_SEL_EVT_MASK;
      default: sel = PCEI_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Write strobe for one register; only byte lane 0 carries register bits
  function automatic logic wr_hit(input logic lane0, input pcei_sel_t hit_sel,
                                  input pcei_sel_t sel);
    return lane0 && (hit_sel == sel);
  endfunction

  // Register state
  pcei_pins_t rise_enable_reg;
  pcei_pins_t fall_enable_reg;
  pcei_pins_t change_flag_reg;
  pcei_pins_t evt_status_reg;
  pcei_pins_t evt_mask_reg;
  pcei_ctrl_t ctrl_reg;

  // Write channel state
  logic aw_held_reg;
  logic [`PCEI_ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // Read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Output state
  logic change_irq_reg;
  logic wake_reg;
  logic irq_reg;

  // Internal signals
  pcei_edge_t edges;
  pcei_pins_t avail;
  pcei_pins_t set_evt;
  pcei_pins_t wr_val;
  pcei_sel_t wr_sel;
  pcei_sel_t rd_sel;
  logic wr_fire;
  logic wr_lane0;
  logic rd_fire;
  logic summary;
  pcei_pins_t change_flag_next;
  pcei_pins_t evt_status_next;
  pcei_pins_t rise_hit;
  pcei_pins_t fall_hit;

  pcei_edge_det u_edge_det (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pins(i_port_a_pin),
    .o_edges(edges)
  );

  // Pins 1 and 0 belong to the debugger while it is attached
  assign avail = i_debug_en ? `PCEI_DBG_PINS : `PCEI_ALL_PINS;
  // Limitation: flags already set on pins 1 and 0 stay until software clears them

  // Armed detectors per polarity; either or both may be on per pin
  // Nothing is flagged while the module is disabled
  genvar p;
  generate
    for (p = 0; p < `PCEI_PIN_W; p++) begin : g_arm
      assign rise_hit[p] = edges.rise[p] & rise_enable_reg[p];
      assign fall_hit[p] = edges.fall[p] & fall_enable_reg[p];
      assign set_evt[p] = (rise_hit[p] | fall_hit[p]) & avail[p] & ~ctrl_reg.mod_dis;
    end
  endgenerate

  // Write takes place once both address and data are held
  // A new write waits until the previous response is taken
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_sel = dec_addr(aw_addr_reg);
  assign wr_lane0 = wr_fire & w_lane0_reg;
  assign wr_val = w_data_reg[`PCEI_PIN_W-1:0];
  assign rd_fire = i_arvalid & ~rvalid_reg;
  assign rd_sel = dec_addr(i_araddr);

  // Summary is only ever derived, never stored
  assign summary = |change_flag_reg;

  // Handshakes
  // Readies are combinational so a held beat is refused in the same cycle
  assign o_awready = ~aw_held_reg;
  assign o_wready = ~w_held_reg;
  assign o_arready = ~rvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_change_irq = change_irq_reg;
  assign o_wake = wake_reg;
  assign o_irq = irq_reg;

  // Write address holding
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (i_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_awaddr;
    end
  end

  // Write data holding; only byte lane 0 carries register bits
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (i_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_lane0_reg <= i_wstrb[0];
    end
  end

  // Write response
  // Unmapped writes answer SLVERR and change nothing
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PCEI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == PCEI_SEL_NONE) ? `PCEI_RESP_SLVERR : `PCEI_RESP_OKAY;
    end else if (i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Edge enables, cleared by every reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rise_enable_reg <= `PCEI_RST_PINS;
      fall_enable_reg <= `PCEI_RST_PINS;
    end else if (wr_lane0) begin
      if (wr_sel == PCEI_SEL_RISE) begin
        rise_enable_reg <= wr_val;
      end
      if (wr_sel == PCEI_SEL_FALL) begin
        fall_enable_reg <= wr_val;
      end
    end
  end

  // Control: master enable and module disable
  // Enables survive a module disable, so re-enabling needs no reprogramming
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_reg <= '0;
    end else if (wr_hit(wr_lane0, wr_sel, PCEI_SEL_CTRL)) begin
      ctrl_reg.master_en <= w_data_reg[`PCEI_CTRL_MASTER_EN];
      ctrl_reg.mod_dis <= w_data_reg[`PCEI_CTRL_MOD_DIS];
    end
  end

  // Next flag value: a hardware set always beats the software write
  always_comb begin
    change_flag_next = change_flag_reg | set_evt;
    if (ctrl_reg.mod_dis) begin
      change_flag_next = `PCEI_RST_PINS;
    end else if (wr_hit(wr_lane0, wr_sel, PCEI_SEL_FLAGS)) begin
      change_flag_next = (wr_val & avail) | set_evt;
    end
  end

  // Change flags: software writes, hardware sets
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      change_flag_reg <= `PCEI_RST_PINS;
    end else begin
      change_flag_reg <= change_flag_next;
    end
  end

  // Next event status: write one to clear, a new edge beats the clear
  always_comb begin
    evt_status_next = evt_status_reg | set_evt;
    if (wr_hit(wr_lane0, wr_sel, PCEI_SEL_EVT)) begin
      evt_status_next = (evt_status_reg & ~wr_val) | set_evt;
    end
  end

  // Event status for o_irq
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      evt_status_reg <= `PCEI_RST_PINS;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  // Event mask
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      evt_mask_reg <= `PCEI_RST_PINS;
    end else if (wr_hit(wr_lane0, wr_sel, PCEI_SEL_EVT_MASK)) begin
      evt_mask_reg <= wr_val;
    end
  end

  // Requests: flags keep setting with master enable clear, only the request is held off
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      change_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      change_irq_reg <= summary & ctrl_reg.master_en;
      // Wake follows the request so a sleeping core sees the same condition
      wake_reg <= summary & ctrl_reg.master_en;
      irq_reg <= |(evt_status_reg & evt_mask_reg);
    end
  end

  // Read channel; unused upper bits read as zero
  // Unaligned or unmapped reads answer SLVERR with zero data
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PCEI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `PCEI_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      case (rd_sel)
        PCEI_SEL_RISE: begin
          rdata_reg[`PCEI_PIN_W-1:0] <= rise_enable_reg & avail;
        end
        PCEI_SEL_FALL: begin
          rdata_reg[`PCEI_PIN_W-1:0] <= fall_enable_reg & avail;
        end
        PCEI_SEL_FLAGS: begin
          rdata_reg[`PCEI_PIN_W-1:0] <= change_flag_reg;
        end
        PCEI_SEL_CTRL: begin
          rdata_reg[`PCEI_CTRL_MASTER_EN] <= ctrl_reg.master_en;
          rdata_reg[`PCEI_CTRL_MOD_DIS] <= ctrl_reg.mod_dis;
        end
        PCEI_SEL_STATUS: begin
          rdata_reg[`PCEI_STAT_SUMMARY] <= summary;
          rdata_reg[`PCEI_STAT_WAKE] <= wake_reg;
        end
        PCEI_SEL_EVT: begin
          rdata_reg[`PCEI_PIN_W-1:0] <= evt_status_reg;
        end
        PCEI_SEL_EVT_MASK: begin
          rdata_reg[`PCEI_PIN_W-1:0] <= evt_mask_reg;
        end
        default: begin
          rresp_reg <= `PCEI_RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* File: sim/pcei_props.sv */
// Purpose: Port checks for pcei_top
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every pcei_top instance
`include "pcei_regs.svh"

module pcei_props
  import pcei_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [`PCEI_ADDR_W-1:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  // Requests
  input wire logic o_change_irq,
  input wire logic o_wake,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_wake_same: assert property (o_wake == o_change_irq)
    else $error("wake differs from change request");
  a_rst_quiet: assert property ($rose(i_rst_b) |-> !o_change_irq && !o_irq)
    else $error("request high straight after reset");
  a_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid
    && o_rresp == ($past(i_araddr) > 8'h18 ? 2'h2 : 2'h0))
    else $error("read answer or response code wrong");
  a_rdata_upper: assert property (o_rvalid |-> o_rdata[31:6] == 26'h0)
    else $error("unimplemented read bits not zero");
  a_ar_block: assert property (o_rvalid |-> !o_arready)
    else $error("second read taken while one open");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:3] o_bvalid)
    else $error("write response late");
  a_bv_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response not released");
  a_rv_drop: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read data not released");

  c_change: cover property ($rose(o_change_irq));
  c_irq: cover property ($rose(o_irq));
  c_slverr: cover property (o_rvalid && o_rresp == 2'h2);
endmodule

bind pcei_top pcei_props u_props (.*);

/* File: sim/pcei_pin_drv.sv */
// Purpose: Port pins seen from outside the block
// Assumes: Pins move with no relation to the clock
// Notes: Slow mode lands past the next clock edge
module pcei_pin_drv
  import pcei_pkg::*;
(
  // Requested level and pace
  input wire pcei_pins_t i_level,
  input wire logic i_slow,
  // Pins toward the block
  output pcei_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_pins = 6'h00;
  always @(i_level) o_pins <= #(i_slow ? 130 : 7) i_level;
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for pcei_top
// Assumes: 10 MHz clock, model kept in bench variables
// Notes: Random register and pin traffic from a fixed seed
`include "pcei_regs.svh"

module testbench
  import pcei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_debug_en;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_change_irq, o_wake, o_irq;
  logic [7:0] i_awaddr, i_araddr;
  logic [2:0] i_awprot, i_arprot;
  logic [31:0] i_wdata, o_rdata, d, r;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rs, mctl, bs;
  pcei_pins_t i_port_a_pin, lvl, m_rise, m_fall, m_flag, m_evt, m_msk, dm;
  logic slow;
  int n_fail, samples_checked, cyc;
  logic [31:0] seed = 32'h51;

  assign dm = i_debug_en ? `PCEI_DBG_PINS : `PCEI_ALL_PINS;
  pcei_top uut (.i_clk, .i_rst_b, .i_awvalid, .o_awready, .i_awaddr, .i_awprot, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_port_a_pin,
    .i_debug_en, .o_change_irq, .o_wake, .o_irq);
  pcei_pin_drv u_pins (.i_level(lvl), .i_slow(slow), .o_pins(i_port_a_pin));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshakes are judged at the falling edge, so the release lands on the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= v;
    i_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid;
      bs = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
    end while (!tb);
    i_bready <= 1'b0;
    chk(bs, (a > 8'h18) ? 2'h2 : 2'h0, "bresp");
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid;
      d = o_rdata;
      rs = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
    end while (!tr);
    i_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp, $sformatf("reg %h", a));
    chk(rs, 2'h0, "rresp");
  endtask

  task automatic drive(input pcei_pins_t v);
    pcei_pins_t ed;
    @(posedge i_clk);
    ed = ((~lvl & v & m_rise) | (lvl & ~v & m_fall)) & dm;
    lvl <= v;
    if (!mctl[1]) begin
      m_flag |= ed;
      m_evt |= ed;
    end
    repeat (8) @(posedge i_clk);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_debug_en, slow} = '0;
    {i_awaddr, i_araddr, i_wdata, i_awprot, i_arprot, lvl} = '0;
    i_wstrb = 4'hF;
    {m_rise, m_fall, m_flag, m_evt, m_msk, mctl} = '0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) rc(a[7:0], 32'h0);
    rd(8'h1C);
    chk({rs, d[29:0]}, 32'h80000000, "unmapped");
    wr(8'h1C, 32'h0);
    for (int i = 0; i < 48; i++) begin
      r = xs();
      case (r[18:16])
        3'h0: begin wr(8'h00, r & dm); m_rise = r[5:0] & dm; end
        3'h1: begin wr(8'h04, r & dm); m_fall = r[5:0] & dm; end
        3'h2: begin
          mctl = {r[2] & r[1], r[0]};
          wr(8'h0C, {30'h0, mctl});
        end
        3'h3: begin wr(8'h18, r); m_msk = r[5:0]; end
        3'h4: begin
          // Clear a random subset of the flags just seen, by AND with the inverted subset
          rd(8'h08);
          chk(d, m_flag, "flag snapshot");
          wr(8'h08, d & (32'hFF ^ (d & r & 32'hFF)));
          m_flag &= ~r[5:0];
        end
        3'h5: begin wr(8'h14, r); m_evt &= ~r[5:0]; end
        3'h6: begin
          // Clearing first keeps pins 1 and 0 free of flags left from before
          wr(8'h08, 32'h0);
          wr(8'h14, 32'h3F);
          {m_flag, m_evt} = '0;
          i_debug_en <= r[20];
        end
        default: begin wr(8'h08, r); m_flag = r[5:0] & dm; end
      endcase
      if (mctl[1]) m_flag = '0;
      slow <= r[21];
      drive(r[13:8]);
      rc(8'h00, m_rise & dm);
      rc(8'h04, m_fall & dm);
      rc(8'h08, m_flag);
      rc(8'h0C, mctl);
      rc(8'h14, m_evt);
      rc(8'h18, m_msk);
      rd(8'h10);
      chk(d[0], |m_flag, "summary");
      chk(d[1], mctl[0] & |m_flag, "wake bit");
      @(negedge i_clk);
      chk(o_change_irq, mctl[0] & |m_flag, "change irq");
      chk(o_wake, mctl[0] & |m_flag, "wake");
      chk(o_irq, |(m_evt & m_msk), "irq");
    end
    // Edges land on the very edge at which the flag clear is written
    slow <= 1'b0;
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h3F);
    wr(8'h04, 32'h3F);
    mctl = 2'h1;
    m_rise = 6'h3F;
    m_fall = 6'h3F;
    @(posedge i_clk);
    lvl <= ~lvl;
    wr(8'h08, 32'h0);
    m_flag = dm;
    m_evt |= dm;
    repeat (4) @(posedge i_clk);
    rc(8'h08, m_flag);
    rc(8'h14, m_evt);
    @(negedge i_clk);
    chk(o_change_irq, 1'b1, "change irq");
    // Mid-run reset clears enables, flags, events and requests again
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    {m_rise, m_fall, m_flag, m_evt, m_msk, mctl} = '0;
    for (int a = 0; a <= 8'h18; a += 4) rc(a[7:0], 32'h0);
    @(negedge i_clk);
    chk(o_change_irq, 1'b0, "change irq after reset");
    chk(o_irq, 1'b0, "irq after reset");
    close_out();
  end
endmodule
